// File: atws_map.vh
// Register map, field positions and reset values of the auto three-wire serial channel.
// Assumes an AHB-Lite slave with 32-bit data; each register takes one word at four times its index.
`ifndef ATWS_MAP_VH
`define ATWS_MAP_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define ATWS_IDX_CLKSEL 16'hff43
`define ATWS_IDX_MODE 16'hff68
`define ATWS_IDX_AUTOCTL 16'hff69
`define ATWS_IDX_SHIFT 16'hff6c
`define ATWS_IDX_PTR 16'hff6d
`define ATWS_IDX_BUFADDR 16'hff6e
`define ATWS_IDX_BUFDATA 16'hff6f

// ==========================================================
// Reset values
`define ATWS_RST_CLKSEL 8'h88
`define ATWS_RST_MODE 8'h00
`define ATWS_RST_AUTOCTL 8'h00
`define ATWS_RST_PTR 5'h00

// ==========================================================
// Mode register fields
`define ATWS_MODE_EN 7
`define ATWS_MODE_DIR 6
`define ATWS_MODE_AUTO 5
`define ATWS_MODE_SRC_HI 1
`define ATWS_MODE_SRC_LO 0
`define ATWS_MODE_WMASK 8'he3

// ==========================================================
// Auto transfer control fields
`define ATWS_ACTL_RXEN 7
`define ATWS_ACTL_RPT 6
`define ATWS_ACTL_ERRCHK 5
`define ATWS_ACTL_ERR 4
`define ATWS_ACTL_ACTIVE 3
`define ATWS_ACTL_STROBE 2
`define ATWS_ACTL_BUSYEN 1
`define ATWS_ACTL_BUSYPOL 0
`define ATWS_ACTL_WMASK 8'he7

// ==========================================================
// Sizes
`define ATWS_PTR_W 5
`define ATWS_BUF_DEPTH 64
`define ATWS_BITS_PER_BYTE 4'h8

`endif

// File: atws_clkdiv.v
// Internal serial clock tick generator: half-period ticks of fx/4 .. fx/512.
// Assumes the select nibble is only changed while no transfer runs.
`timescale 1ns/10ps

module atws_clkdiv (
  input wire ref_clk,
  input wire rst,
  input wire ce,
  input wire run,
  input wire [3:0] sel,
  output reg tick
);

  // ==========================================================
  // Select decode
  // Returns {valid, half period minus one}; prohibited codes give no tick at all
  function [8:0] halfLimit;
    input [3:0] code;
    begin
      case (code)
        4'h6: halfLimit = {1'b1, 8'h01};
        4'h7: halfLimit = {1'b1, 8'h03};
        4'h8: halfLimit = {1'b1, 8'h07};
        4'h9: halfLimit = {1'b1, 8'h0f};
        4'ha: halfLimit = {1'b1, 8'h1f};
        4'hb: halfLimit = {1'b1, 8'h3f};
        4'hc: halfLimit = {1'b1, 8'h7f};
        4'hd: halfLimit = {1'b1, 8'hff};
        default: halfLimit = {1'b0, 8'h00};
      endcase
    end
  endfunction

  wire [8:0] lim = halfLimit(sel);
  reg [7:0] count;

  // ==========================================================
  // Counter
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count <= 8'h00;
      tick <= 1'b0;
    end else if (ce) begin
      if (!run || !lim[8]) begin
        count <= 8'h00;
        tick <= 1'b0;
      end else if (count == lim[7:0]) begin
        count <= 8'h00;
        tick <= 1'b1;
      end else begin
        count <= count + 8'h01;
        tick <= 1'b0;
      end
    end
  end

endmodule // atws_clkdiv

// File: atws_core.v
// Auto three-wire serial channel: AHB-Lite registers, shift engine, automatic multi-byte transfer.
// Assumes pins are synchronous to ref_clk and the bus master issues single word transfers.
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "atws_map.vh"

module atws_core (
  input wire ref_clk,
  input wire rst,
  input wire ce,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire serialClockPinIn,
  output reg serialClockPinOut,
  output reg serialClockPinOe,
  output reg serialOutPin,
  output reg serialOutPinOe,
  input wire serialInPin,
  output reg serialInPinReleased,
  input wire threeBitTimerTick,
  input wire busyIn,
  output reg strobeOut,
  output reg channelIrqFlag
);

  // ==========================================================
  // Address decode
  // Returns {hit, index}; an unaligned or out-of-range address misses
  function [16:0] regIdx;
    input [31:0] a;
    begin
      regIdx = {(a[31:18] == 14'h0000) && (a[1:0] == 2'b00), a[17:2]};
    end
  endfunction

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_SHIFT = 2'd1;
  localparam [1:0] ST_GAP = 2'd2;

  reg [7:0] clkSel;
  reg [7:0] modeReg;
  reg [7:0] autoCtl;
  reg transferActive;
  reg autoErr;
  reg [7:0] shiftReg;
  reg [`ATWS_PTR_W-1:0] ptr;
  reg [`ATWS_PTR_W-1:0] ptrStart;
  reg [5:0] bufAddr;
  reg [7:0] bufMem [0:`ATWS_BUF_DEPTH-1];
  reg [1:0] state;
  reg [3:0] bitCnt;
  reg sckPrev;
  reg gapTickSeen;
  reg wrPend;
  reg [16:0] wrIdx;

  wire [16:0] addrIdx = regIdx(haddr);
  wire addrPhase = hsel & htrans[1] & hready;
  wire [7:0] wrData = hwdata[7:0];
  wire enable = modeReg[`ATWS_MODE_EN];
  wire dirLsb = modeReg[`ATWS_MODE_DIR];
  wire autoMode = modeReg[`ATWS_MODE_AUTO];
  wire srcExt = ~modeReg[`ATWS_MODE_SRC_HI];
  wire recvOn = autoCtl[`ATWS_ACTL_RXEN];
  wire busyOn = autoCtl[`ATWS_ACTL_BUSYEN];
  wire errCheck = autoCtl[`ATWS_ACTL_ERRCHK] & busyOn;
  // Busy polarity bit picks the active level of the busy input
  wire busyActive = busyOn & (busyIn ^ autoCtl[`ATWS_ACTL_BUSYPOL]);
  wire running = enable & (state == ST_SHIFT);

  // ==========================================================
  // Serial clock sources
  wire divTick;
  atws_clkdiv uDiv (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .run(enable & (state != ST_IDLE)),
    .sel(clkSel[7:4]),
    .tick(divTick)
  );

  // Internal source toggles the clock pin on each tick; an external clock is edge-detected
  wire intTick = modeReg[`ATWS_MODE_SRC_LO] ? divTick : threeBitTimerTick;
  wire fallEv = running & (srcExt ? (sckPrev & ~serialClockPinIn) : (intTick & serialClockPinOut));
  wire riseEv = running & (srcExt ? (~sckPrev & serialClockPinIn) : (intTick & ~serialClockPinOut));
  wire gapTick = srcExt | intTick;
  wire [7:0] nextShift = dirLsb ? {serialInPin, shiftReg[7:1]} : {shiftReg[6:0], serialInPin};
  wire lastBit = (bitCnt == `ATWS_BITS_PER_BYTE - 4'h1);

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend <= 1'b0;
      wrIdx <= 17'h00000;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend <= addrPhase & hwrite;
      wrIdx <= addrIdx;
      if (addrPhase && !hwrite) begin
        hrdata <= 32'h00000000;
        if (addrIdx[16]) begin
          case (addrIdx[15:0])
            `ATWS_IDX_CLKSEL: hrdata[7:0] <= clkSel;
            `ATWS_IDX_MODE: hrdata[7:0] <= modeReg;
            `ATWS_IDX_AUTOCTL: hrdata[7:0] <= {autoCtl[7:5], autoErr, transferActive, autoCtl[2:0]};
            `ATWS_IDX_SHIFT: hrdata[7:0] <= shiftReg;
            `ATWS_IDX_PTR: hrdata[7:0] <= {3'b000, ptr};
            `ATWS_IDX_BUFADDR: hrdata[7:0] <= {2'b00, bufAddr};
            `ATWS_IDX_BUFDATA: hrdata[7:0] <= bufMem[bufAddr];
            default: hrdata <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // Write strobe for one register index; misses and reads give none
  function wrHit;
    input [16:0] idx;
    input [15:0] want;
    begin
      wrHit = idx[16] && (idx[15:0] == want);
    end
  endfunction

  wire wrClk = wrPend & wrHit(wrIdx, `ATWS_IDX_CLKSEL);
  wire wrMode = wrPend & wrHit(wrIdx, `ATWS_IDX_MODE);
  wire wrAuto = wrPend & wrHit(wrIdx, `ATWS_IDX_AUTOCTL);
  wire wrShift = wrPend & wrHit(wrIdx, `ATWS_IDX_SHIFT);
  wire wrPtr = wrPend & wrHit(wrIdx, `ATWS_IDX_PTR);
  wire wrBufA = wrPend & wrHit(wrIdx, `ATWS_IDX_BUFADDR);
  wire wrBufD = wrPend & wrHit(wrIdx, `ATWS_IDX_BUFDATA);
  wire autoRecv = autoMode & recvOn & (state == ST_SHIFT) & riseEv & lastBit;

  // ==========================================================
  // Byte buffer: the engine's received byte wins over a software write
  always @(posedge ref_clk) begin
    if (ce) begin
      if (autoRecv) begin
        bufMem[{1'b0, ptr}] <= nextShift;
      end else if (wrBufD) begin
        bufMem[bufAddr] <= wrData;
      end
    end
  end

  // ==========================================================
  // Control registers
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clkSel <= `ATWS_RST_CLKSEL;
      modeReg <= `ATWS_RST_MODE;
      autoCtl <= `ATWS_RST_AUTOCTL;
      bufAddr <= 6'h00;
    end else if (ce) begin
      // Any nibble is stored; a prohibited one just stops the divider, so the serial clock stops when the divider is the source
      if (wrClk) begin
        clkSel <= wrData;
      end
      if (wrMode) begin
        modeReg <= wrData & `ATWS_MODE_WMASK;
      end
      if (wrAuto) begin
        autoCtl <= wrData & `ATWS_ACTL_WMASK;
      end
      if (wrBufA) begin
        bufAddr <= wrData[5:0];
      end
    end
  end

  // ==========================================================
  // Shift engine and automatic transfer sequencer
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      shiftReg <= 8'h00;
      bitCnt <= 4'h0;
      ptr <= `ATWS_RST_PTR;
      ptrStart <= `ATWS_RST_PTR;
      transferActive <= 1'b0;
      autoErr <= 1'b0;
      sckPrev <= 1'b1;
      gapTickSeen <= 1'b0;
      serialClockPinOut <= 1'b1;
      serialOutPin <= 1'b1;
      strobeOut <= 1'b0;
      channelIrqFlag <= 1'b0;
    end else if (ce) begin
      sckPrev <= serialClockPinIn;
      channelIrqFlag <= 1'b0;
      if (wrPtr) begin
        ptr <= wrData[`ATWS_PTR_W-1:0];
      end
      if (!enable) begin
        // Disabling the channel aborts any transfer
        state <= ST_IDLE;
        bitCnt <= 4'h0;
        transferActive <= 1'b0;
        serialClockPinOut <= 1'b1;
        strobeOut <= 1'b0;
        if (wrShift) begin
          shiftReg <= wrData;
        end
      end else if (wrShift) begin
        // A write restarts the engine; writing mid-transfer is a software fault
        state <= ST_SHIFT;
        bitCnt <= 4'h0;
        transferActive <= 1'b1;
        autoErr <= 1'b0;
        serialClockPinOut <= 1'b1;
        strobeOut <= 1'b0;
        if (autoMode) begin
          ptrStart <= ptr;
          shiftReg <= bufMem[{1'b0, ptr}];
        end else begin
          shiftReg <= wrData;
        end
      end else begin
        case (state)
          ST_SHIFT: begin
            if (!srcExt && intTick) begin
              serialClockPinOut <= ~serialClockPinOut;
            end
            if (fallEv) begin
              serialOutPin <= dirLsb ? shiftReg[0] : shiftReg[7];
            end
            if (riseEv) begin
              shiftReg <= nextShift;
              if (lastBit) begin
                bitCnt <= 4'h0;
                if (autoMode) begin
                  state <= ST_GAP;
                  gapTickSeen <= 1'b0;
                  strobeOut <= autoCtl[`ATWS_ACTL_STROBE];
                  if (errCheck && busyActive) begin
                    // Partner still busy when a byte was forced on it
                    autoErr <= 1'b1;
                    transferActive <= 1'b0;
                    state <= ST_IDLE;
                    strobeOut <= 1'b0;
                    channelIrqFlag <= 1'b1;
                  end
                end else begin
                  state <= ST_IDLE;
                  transferActive <= 1'b0;
                  channelIrqFlag <= 1'b1;
                end
              end else begin
                bitCnt <= bitCnt + 4'h1;
              end
            end
          end
          ST_GAP: begin
            if (gapTick) begin
              gapTickSeen <= 1'b1;
              strobeOut <= 1'b0;
            end
            if (gapTickSeen && !busyActive) begin
              if (ptr == `ATWS_RST_PTR) begin
                if (autoCtl[`ATWS_ACTL_RPT]) begin
                  ptr <= ptrStart;
                  shiftReg <= bufMem[{1'b0, ptrStart}];
                  state <= ST_SHIFT;
                end else begin
                  state <= ST_IDLE;
                  transferActive <= 1'b0;
                  channelIrqFlag <= 1'b1;
                end
              end else begin
                ptr <= ptr - 5'h01;
                shiftReg <= bufMem[{1'b0, ptr - 5'h01}];
                state <= ST_SHIFT;
              end
            end
          end
          ST_IDLE: begin
            serialClockPinOut <= 1'b1;
            strobeOut <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Pin ownership
  // Enables trail the mode register by one cycle, so a pin changes owner a cycle after the write
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      serialClockPinOe <= 1'b0;
      serialOutPinOe <= 1'b0;
      serialInPinReleased <= 1'b1;
    end else if (ce) begin
      serialClockPinOe <= enable & ~srcExt;
      serialOutPinOe <= enable;
      serialInPinReleased <= ~enable | ~recvOn;
    end
  end

endmodule // atws_core

// File: atws_core_assertions.sv
// Port checker for the serial channel core.
// Assumes it is bound to atws_core and sees only its ports.
`timescale 1ns/10ps
module atws_core_assertions (
  input wire ref_clk,
  input wire rst,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire serialClockPinOut,
  input wire serialClockPinOe,
  input wire serialOutPinOe,
  input wire serialInPinReleased,
  input wire strobeOut,
  input wire channelIrqFlag
);
  // ======
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  chk_rdata_byte: assert property (hrdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  chk_clk_idle: assert property (!$past(serialOutPinOe) && !serialOutPinOe |-> serialClockPinOut)
    else $error("serial clock not high while disabled");
  chk_clk_oe: assert property (serialClockPinOe |-> serialOutPinOe)
    else $error("clock driven while channel disabled");
  chk_in_free: assert property (!serialOutPinOe |-> serialInPinReleased)
    else $error("input pin held while disabled");
  chk_irq_pulse: assert property (channelIrqFlag |=> !channelIrqFlag)
    else $error("byte done flag longer than one cycle");
  chk_irq_enabled: assert property (channelIrqFlag |-> $past(serialOutPinOe))
    else $error("byte done flag while disabled");
  chk_strobe_enabled: assert property (strobeOut |-> $past(serialOutPinOe))
    else $error("strobe while disabled");
  cover property (channelIrqFlag);
  cover property (strobeOut);
  cover property (serialClockPinOe ##1 !serialClockPinOe);
endmodule // atws_core_assertions

bind atws_core atws_core_assertions i_atws_core_assertions (.ref_clk(ref_clk), .rst(rst), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .serialClockPinOut(serialClockPinOut), .serialClockPinOe(serialClockPinOe),
  .serialOutPinOe(serialOutPinOe), .serialInPinReleased(serialInPinReleased), .strobeOut(strobeOut),
  .channelIrqFlag(channelIrqFlag));

// File: atws_peer.sv
// Far-side peripheral with a clocked serial port.
// Assumes the clock pin level is resolved by the bench, synchronous to ref_clk.
`timescale 1ns/10ps
module atws_peer (
  input wire ref_clk,
  input wire rst,
  input wire sck,
  input wire sdo,
  input wire [7:0] txByte,
  output reg sdi,
  output reg [7:0] rxByte,
  output reg [7:0] nBytes
);
  reg sckLast;
  reg [2:0] bitIdx;
  // ======
  // Capture on rise, launch on fall
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sckLast <= 1'b1;
      bitIdx <= 3'h0;
      sdi <= 1'b1;
      rxByte <= 8'h00;
      nBytes <= 8'h00;
    end else begin
      sckLast <= sck;
      if (sck && !sckLast) begin
        rxByte <= {rxByte[6:0], sdo};
        bitIdx <= bitIdx + 3'h1;
        if (bitIdx == 3'h7) nBytes <= nBytes + 8'h01;
      end else if (!sck && sckLast) begin
        sdi <= txByte[3'h7 - bitIdx];
      end else if (bitIdx == 3'h0 && sck) begin
        // Between frames the line carries no data, so never leave a stale bit
        sdi <= ~sdi;
      end
    end
  end
endmodule // atws_peer

// File: auto_three_wire_serial_bench.sv
// Bench: AHB-Lite master plus serial peer around the channel core.
// Assumes atws_map.vh indices; byte address is four times the index.
`timescale 1ns/10ps
`include "atws_map.vh"
module auto_three_wire_serial_bench;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg extClk = 1'b1;
  reg tmrTick = 1'b0;
  reg busyIn = 1'b0;
  reg [7:0] ptx = 8'h00;
  wire [31:0] hrdata;
  wire hreadyout, hresp, sckOut, sckOe, sdo, sdoOe, sdi, siRel, strobeOut, irq;
  wire [7:0] prx, pnb;
  wire sck = sckOe ? sckOut : extClk;
  integer seed = 26485;
  integer mismatches = 0, checked = 0, cyc = 0, irqs = 0, strobes = 0;

  atws_core i_atws_core (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .serialClockPinIn(sck), .serialClockPinOut(sckOut), .serialClockPinOe(sckOe),
    .serialOutPin(sdo), .serialOutPinOe(sdoOe), .serialInPin(sdi), .serialInPinReleased(siRel),
    .threeBitTimerTick(tmrTick), .busyIn(busyIn), .strobeOut(strobeOut), .channelIrqFlag(irq));
  atws_peer i_atws_peer (.ref_clk(ref_clk), .rst(rst), .sck(sck), .sdo(sdo), .txByte(ptx), .sdi(sdi),
    .rxByte(prx), .nBytes(pnb));

  always #4 ref_clk = ~ref_clk;
  // ======
  // Event counters, timer ticks and hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    tmrTick <= (cyc % 3 == 0);
    if (irq === 1'b1) irqs <= irqs + 1;
    if (strobeOut === 1'b1) strobes <= strobes + 1;
    if (cyc == 60000) begin
      mismatches = mismatches + 1;
      end_of_test;
    end
  end
  // ======
  // Tasks
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    checked = checked + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD %0s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task bus(input w, input [15:0] idx, input [7:0] wd, output [7:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {14'h0, idx, 2'h0};
    hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd = hrdata[7:0];
  endtask
  task wr(input [15:0] idx, input [7:0] d);
    reg [7:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task rc(input [15:0] idx, input [7:0] exp, input string what);
    reg [7:0] x;
    bus(1'b0, idx, 8'h00, x);
    chk({24'h0, x}, {24'h0, exp}, what);
  endtask
  task waitIrq(input integer n);
    integer i0, k;
    i0 = irqs;
    for (k = 0; k < n && irqs == i0; k = k + 1) @(posedge ref_clk);
  endtask
  task lvl(input v, output integer c);
    for (c = 0; c < 700 && sckOut === v; c = c + 1) @(posedge ref_clk);
  endtask
  function [7:0] rev(input [7:0] v);
    integer i;
    for (i = 0; i < 8; i = i + 1) rev[i] = v[7 - i];
  endfunction
  task end_of_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ======
  // Main sequence
  initial begin : main
    integer i, n, a, b, ic, nb;
    reg [7:0] d;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rc(`ATWS_IDX_CLKSEL, 8'h88, "clkSel reset");
    rc(`ATWS_IDX_MODE, 8'h00, "mode reset");
    rc(`ATWS_IDX_PTR, 8'h00, "ptr reset");
    wr(`ATWS_IDX_PTR, 8'hff);
    rc(`ATWS_IDX_PTR, 8'h1f, "ptr width");
    wr(`ATWS_IDX_AUTOCTL, 8'hff);
    rc(`ATWS_IDX_AUTOCTL, 8'he7, "auto ctl read-only");
    wr(16'hff70, 8'h5a);
    rc(16'hff70, 8'h00, "unmapped");
    wr(`ATWS_IDX_AUTOCTL, 8'h80);
    wr(`ATWS_IDX_MODE, 8'h03);
    nb = pnb;
    wr(`ATWS_IDX_SHIFT, 8'ha5);
    repeat (300) @(posedge ref_clk);
    chk(pnb, nb, "bytes while disabled");
    chk(sckOe, 1'b0, "clock oe disabled");
    for (i = 0; i < 8; i = i + 1) begin
      d = 8'($random(seed));
      ptx <= 8'($random(seed));
      wr(`ATWS_IDX_MODE, {1'b1, i[0], 4'h0, 1'b1, i[1]});
      // Pin release follows the mode write one cycle late
      repeat (2) @(posedge ref_clk);
      chk(siRel, 1'b0, "input pin used");
      ic = irqs;
      wr(`ATWS_IDX_SHIFT, d);
      rc(`ATWS_IDX_AUTOCTL, 8'h88, "active flag set");
      waitIrq(3000);
      chk(irqs - ic, 1, "byte done");
      chk(prx, i[0] ? rev(d) : d, "peer rx");
      rc(`ATWS_IDX_SHIFT, i[0] ? rev(ptx) : ptx, "shift rx");
      rc(`ATWS_IDX_AUTOCTL, 8'h80, "active flag clear");
    end
    wr(`ATWS_IDX_MODE, 8'h83);
    for (n = 6; n < 14; n = n + 1) begin
      wr(`ATWS_IDX_CLKSEL, {n[3:0], 4'h8});
      wr(`ATWS_IDX_SHIFT, 8'h3c);
      lvl(1'b1, a);
      lvl(1'b0, a);
      lvl(1'b1, b);
      chk(a + b, 1 << (n - 4), "clock period");
      waitIrq(5000);
    end
    // A prohibited nibble leaves the serial clock parked high
    wr(`ATWS_IDX_CLKSEL, 8'h08);
    wr(`ATWS_IDX_SHIFT, 8'h3c);
    lvl(1'b1, a);
    chk(a, 700, "no clock on prohibited code");
    wr(`ATWS_IDX_MODE, 8'h03);
    wr(`ATWS_IDX_CLKSEL, 8'h88);
    wr(`ATWS_IDX_MODE, 8'h80);
    ic = irqs;
    ptx <= 8'hc3;
    wr(`ATWS_IDX_SHIFT, 8'h96);
    for (i = 0; i < 16; i = i + 1) begin
      repeat (6) @(posedge ref_clk);
      extClk <= ~extClk;
    end
    chk(sckOe, 1'b0, "external clock oe");
    repeat (4) @(posedge ref_clk);
    chk(irqs - ic, 1, "external byte done");
    rc(`ATWS_IDX_SHIFT, 8'hc3, "external rx");
    wr(`ATWS_IDX_MODE, 8'ha3);
    ptx <= 8'h5e;
    for (i = 0; i < 3; i = i + 1) begin
      wr(`ATWS_IDX_BUFADDR, i[7:0]);
      wr(`ATWS_IDX_BUFDATA, 8'h10 + i[7:0]);
    end
    wr(`ATWS_IDX_PTR, 8'h02);
    wr(`ATWS_IDX_AUTOCTL, 8'h86);
    busyIn <= 1'b1;
    nb = pnb;
    ic = irqs;
    wr(`ATWS_IDX_SHIFT, 8'h00);
    rc(`ATWS_IDX_AUTOCTL, 8'h8e, "auto active");
    repeat (400) @(posedge ref_clk);
    chk(pnb - nb, 1, "busy holds off");
    busyIn <= 1'b0;
    waitIrq(3000);
    chk(pnb - nb, 3, "auto byte count");
    chk(irqs - ic, 1, "single run done");
    chk(prx, 8'h10, "last auto byte");
    chk(strobes > 0, 1, "strobe seen");
    rc(`ATWS_IDX_AUTOCTL, 8'h86, "auto finished");
    rc(`ATWS_IDX_PTR, 8'h00, "ptr end");
    wr(`ATWS_IDX_BUFADDR, 8'h01);
    rc(`ATWS_IDX_BUFDATA, 8'h5e, "buffer rx");
    wr(`ATWS_IDX_PTR, 8'h01);
    wr(`ATWS_IDX_AUTOCTL, 8'h23);
    wr(`ATWS_IDX_SHIFT, 8'h00);
    waitIrq(3000);
    rc(`ATWS_IDX_AUTOCTL, 8'h33, "error set");
    busyIn <= 1'b1;
    wr(`ATWS_IDX_SHIFT, 8'h00);
    rc(`ATWS_IDX_AUTOCTL, 8'h2b, "error cleared");
    waitIrq(6000);
    wr(`ATWS_IDX_PTR, 8'h01);
    wr(`ATWS_IDX_AUTOCTL, 8'h40);
    ic = irqs;
    wr(`ATWS_IDX_SHIFT, 8'h00);
    repeat (700) @(posedge ref_clk);
    chk(irqs - ic, 0, "repeat runs on");
    rc(`ATWS_IDX_AUTOCTL, 8'h48, "repeat active");
    chk(siRel, 1'b1, "input free without receive");
    wr(`ATWS_IDX_MODE, 8'h23);
    // The abort lands one cycle after the mode write
    @(posedge ref_clk);
    rc(`ATWS_IDX_AUTOCTL, 8'h40, "abort clears flag");
    chk(siRel, 1'b1, "input released");
    end_of_test;
  end
endmodule // auto_three_wire_serial_bench
